// >>> eiu_defines.svh
// Register offsets, field positions and reset values of the external pin interrupt unit
`ifndef EIU_DEFINES_SVH
`define EIU_DEFINES_SVH

`define EIU_ADDR_W             6
`define EIU_ADDR_MCU_CONTROL   6'h35
`define EIU_ADDR_GIM           6'h3B
`define EIU_ADDR_FLAGS         6'h3A
`define EIU_ADDR_PC_MASK_A     6'h23
`define EIU_ADDR_PC_MASK_B     6'h22

`define EIU_MCU_CONTROL_RST    8'h00
`define EIU_MCU_CONTROL_WMASK  8'h7B
`define EIU_GIM_RST            8'h00
`define EIU_GIM_WMASK          8'hF0
`define EIU_PC_MASK_A_RST      8'hC8
`define EIU_PC_MASK_B_RST      8'hFF

`define EIU_BIT_PIN_B          7
`define EIU_BIT_PIN_A          6
`define EIU_BIT_PC_HI          5
`define EIU_BIT_PC_LO          4
`define EIU_BIT_PC_FLAG        5
`define EIU_BIT_PULLUP_DIS     6
`define EIU_BIT_SLEEP_EN       5
`define EIU_BIT_SLEEP_MODE_HI  4
`define EIU_BIT_SLEEP_MODE_LO  3
`define EIU_BIT_SENSE_HI       1
`define EIU_BIT_SENSE_LO       0

`define EIU_PC_LO_GROUP        16'h0F00

`endif

// >>> eiu_pkg.sv
// Types shared by the external pin interrupt unit
package eiu_pkg;

  typedef enum logic [1:0] {
    EIU_SENSE_LOW  = 2'h0,
    EIU_SENSE_ANY  = 2'h1,
    EIU_SENSE_FALL = 2'h2,
    EIU_SENSE_RISE = 2'h3
  } eiu_sense_t;

  typedef struct packed {
    logic [7:0]  mcu_control;
    logic [7:0]  gim;
    logic [1:0]  ext_flag;
    logic        pc_flag;
    logic [15:0] pc_mask;
    logic [1:0]  ext_prev;
    logic [15:0] pc_prev;
    logic        prev_valid;
    logic [7:0]  rdata;
  } eiu_state_t;

endpackage : eiu_pkg

// >>> eiu_sync.sv
// Three-stage pin synchroniser with agreement filter
module eiu_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout,
  output logic              settled
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] filt;
    logic [1:0]   cnt;
  } eiu_sync_t;

  eiu_sync_t st;
  eiu_sync_t next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // A bit only moves once stages two and three agree
    for (int i = 0; i < W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.filt[i] = st.s3[i];
      end
    end
    // Until the count fills, the filter tracks stage two so no false edge follows reset
    if (st.cnt != 2'h3) begin
      next_st.cnt  = st.cnt + 2'h1;
      next_st.filt = st.s2;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout    = st.filt;
  assign settled = (st.cnt == 2'h3);

endmodule : eiu_sync

// >>> eiu_trig.sv
// Sense decoder for one dedicated interrupt pin
module eiu_trig (
  input  wire logic [1:0] sense,
  input  wire logic       cur,
  input  wire logic       prev,
  output logic            hit,
  output logic            level_mode
);

  always_comb begin
    hit        = 1'b0;
    level_mode = 1'b0;
    unique case (eiu_pkg::eiu_sense_t'(sense))
      eiu_pkg::EIU_SENSE_LOW: begin
        level_mode = 1'b1;
        hit        = ~cur;
      end
      eiu_pkg::EIU_SENSE_ANY: begin
        hit = cur ^ prev;
      end
      eiu_pkg::EIU_SENSE_FALL: begin
        hit = prev & ~cur;
      end
      eiu_pkg::EIU_SENSE_RISE: begin
        hit = cur & ~prev;
      end
    endcase
  end

endmodule : eiu_trig

// >>> eiu_top.sv
// External pin interrupt unit: dedicated pins, pin-change inputs and control registers
//
// Notes on behaviour
// R1: Pins trigger even when driven as outputs.
// R2: Any enabled pin-change input toggle requests.
// R3: Pin-change wake detected without a clock.
// R4: Dedicated pin edges need the running clock.
// R5: Low level on pin A wakes clocklessly.
// R6: Level mode requests while pin stays low.
// R7: Level must outlast start-up to interrupt.
// R8: Sense codes: low, change, fall, rise.
// R9: Pins sampled before edge detection.
// R10: Source holds low through current instruction.
// R11: Request needs global flag and mask.
// R12: Mask bit 7 enables pin B.
// R13: Mask bit 6 enables pin A.
// R14: Mask bit 5 enables inputs 7:0, 15:12.
// R15: Mask bit 4 enables inputs 11:8.
// R16: Each pin-change input individually masked.
// R17: Mask bits 3:0 read zero.
// R18: Control register layout with zero bits.
// R19: Dedicated flags set, cleared, held clear.
// R20: Pin-change flag set, cleared by handler/write.
// R21: Synchronise pins, keep async wake path.
//
// The strobed register port was chosen for this implementation.
`include "eiu_defines.svh"

module eiu_top (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic [`EIU_ADDR_W-1:0] addr,
  input  wire logic [7:0]            wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic      [7:0]            rdata,
  input  wire logic                  ext_irq_pin_a,
  input  wire logic                  ext_irq_pin_b,
  input  wire logic [15:0]           pin_change_inputs,
  input  wire logic                  global_int_enable,
  input  wire logic                  ack_pin_a,
  input  wire logic                  ack_pin_b,
  input  wire logic                  ack_pin_change,
  output logic                       irq_pin_a,
  output logic                       irq_pin_b,
  output logic                       irq_pin_change,
  output logic                       wake_req,
  output logic                       pullup_disable,
  output logic                       sleep_enable,
  output logic                       sleep_mode_hi,
  output logic                       sleep_mode_lo
);

  eiu_pkg::eiu_state_t st;
  eiu_pkg::eiu_state_t next_st;

  logic [1:0]  ext_raw;
  logic [1:0]  ext_sync;
  logic        ext_settled;
  logic [15:0] pc_sync;
  logic        pc_settled;
  logic [1:0]  ext_hit;
  logic [1:0]  ext_level;
  logic [1:0]  ext_en;
  logic [1:0]  ext_ack;
  logic [1:0]  ext_req;
  logic [1:0]  sense;
  logic [15:0] pc_en;
  logic        pc_change;
  logic        pc_async_change;
  logic        wr_flags;

  assign ext_raw = {ext_irq_pin_b, ext_irq_pin_a};
  assign ext_ack = {ack_pin_b, ack_pin_a};
  assign sense   = {st.mcu_control[`EIU_BIT_SENSE_HI], st.mcu_control[`EIU_BIT_SENSE_LO]}; // R8
  assign ext_en  = {st.gim[`EIU_BIT_PIN_B], st.gim[`EIU_BIT_PIN_A]}; // R12 R13

  // Pin values are read straight from the pad, so driving them as outputs still triggers
  eiu_sync #(
    .W (2)
  ) u_ext_sync (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .din     (ext_raw), // R1 R21
    .dout    (ext_sync), // R9
    .settled (ext_settled)
  );

  eiu_sync #(
    .W (16)
  ) u_pc_sync (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .din     (pin_change_inputs), // R21
    .dout    (pc_sync),
    .settled (pc_settled)
  );

  for (genvar g = 0; g < 2; g++) begin : g_ext
    eiu_trig u_trig (
      .sense      (sense),
      .cur        (ext_sync[g]),
      .prev       (st.ext_prev[g]),
      .hit        (ext_hit[g]), // R4 R9
      .level_mode (ext_level[g])
    );
  end

  // Group enables: bit 5 covers inputs 7:0 and 15:12, bit 4 covers 11:8
  assign pc_en = st.pc_mask
               & ((`EIU_PC_LO_GROUP & {16{st.gim[`EIU_BIT_PC_LO]}})          // R15
               | (~`EIU_PC_LO_GROUP & {16{st.gim[`EIU_BIT_PC_HI]}}));        // R14 R16

  assign pc_change       = st.prev_valid & (|((pc_sync ^ st.pc_prev) & pc_en)); // R2
  // Clockless compare of the raw pads against the last settled value
  assign pc_async_change = st.prev_valid & (|((pin_change_inputs ^ st.pc_prev) & pc_en)); // R3

  assign wr_flags = wr & (addr == `EIU_ADDR_FLAGS);

  always_comb begin
    next_st            = st;
    next_st.rdata      = 8'h00;
    next_st.ext_prev   = ext_sync;
    next_st.pc_prev    = pc_sync;
    next_st.prev_valid = ext_settled & pc_settled;

    if (wr) begin
      unique case (addr)
        `EIU_ADDR_MCU_CONTROL: begin
          next_st.mcu_control = wdata & `EIU_MCU_CONTROL_WMASK; // R18
        end
        `EIU_ADDR_GIM: begin
          next_st.gim = wdata & `EIU_GIM_WMASK; // R17
        end
        `EIU_ADDR_PC_MASK_A: begin
          next_st.pc_mask[7:0] = wdata; // R16
        end
        `EIU_ADDR_PC_MASK_B: begin
          next_st.pc_mask[15:8] = wdata; // R16
        end
        default: begin
        end
      endcase
    end

    // Set wins over clear; level mode holds the flag at zero
    for (int i = 0; i < 2; i++) begin
      if (ext_level[i]) begin
        next_st.ext_flag[i] = 1'b0; // R19
      end else if (st.prev_valid && ext_hit[i]) begin
        next_st.ext_flag[i] = 1'b1; // R19
      end else if (ext_ack[i] || (wr_flags && wdata[`EIU_BIT_PIN_A + i])) begin
        next_st.ext_flag[i] = 1'b0; // R19
      end
    end

    if (pc_change) begin
      next_st.pc_flag = 1'b1; // R20
    end else if (ack_pin_change || (wr_flags && wdata[`EIU_BIT_PC_FLAG])) begin
      next_st.pc_flag = 1'b0; // R20
    end

    if (rd) begin
      unique case (addr)
        `EIU_ADDR_MCU_CONTROL: begin
          next_st.rdata = st.mcu_control; // R18
        end
        `EIU_ADDR_GIM: begin
          next_st.rdata = st.gim; // R17
        end
        `EIU_ADDR_FLAGS: begin
          next_st.rdata = {st.ext_flag, st.pc_flag, 5'h00};
        end
        `EIU_ADDR_PC_MASK_A: begin
          next_st.rdata = st.pc_mask[7:0];
        end
        `EIU_ADDR_PC_MASK_B: begin
          next_st.rdata = st.pc_mask[15:8];
        end
        default: begin
          next_st.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st             <= '0;
      st.mcu_control <= `EIU_MCU_CONTROL_RST;
      st.gim         <= `EIU_GIM_RST;
      st.pc_mask     <= {`EIU_PC_MASK_B_RST, `EIU_PC_MASK_A_RST};
    end else begin
      st <= next_st;
    end
  end

  // Level mode requests straight from the synchronised pin for as long as it is low
  for (genvar g = 0; g < 2; g++) begin : g_req
    assign ext_req[g] = ext_en[g] & global_int_enable
                      & (ext_level[g] ? (st.prev_valid & ~ext_sync[g]) : st.ext_flag[g]); // R6 R11
  end

  assign irq_pin_a      = ext_req[0]; // R13
  assign irq_pin_b      = ext_req[1]; // R12
  assign irq_pin_change = global_int_enable & (|st.gim[`EIU_BIT_PC_HI:`EIU_BIT_PC_LO])
                        & st.pc_flag; // R11 R14 R15

  // Wake needs no clock: low level on pin A or a raw pin change; level may vanish before start-up
  assign wake_req = (ext_en[0] & ext_level[0] & ~ext_irq_pin_a) | pc_async_change; // R3 R5 R7

  assign rdata          = st.rdata;
  assign pullup_disable = st.mcu_control[`EIU_BIT_PULLUP_DIS];
  assign sleep_enable   = st.mcu_control[`EIU_BIT_SLEEP_EN];
  assign sleep_mode_hi  = st.mcu_control[`EIU_BIT_SLEEP_MODE_HI];
  assign sleep_mode_lo  = st.mcu_control[`EIU_BIT_SLEEP_MODE_LO];

endmodule : eiu_top

// >>> eiu_chk.sv
// Port assertions for the external pin interrupt unit
module eiu_chk (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       ext_irq_pin_a,
  input wire logic       global_int_enable,
  input wire logic       irq_pin_a,
  input wire logic       irq_pin_b,
  input wire logic       irq_pin_change,
  input wire logic       wake_req,
  input wire logic       pullup_disable,
  input wire logic       sleep_enable,
  input wire logic       sleep_mode_hi,
  input wire logic       sleep_mode_lo
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [7:0] g;
  logic [7:0] c;
  logic       lvl;
  // Shadows of the mask and control registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      g <= 8'h00;
      c <= 8'h00;
    end else if (wr) begin
      if (addr == 6'h3B) g <= wdata;
      if (addr == 6'h35) c <= wdata;
    end
  end
  assign lvl = c[1:0] == 2'h0 && g[6] && !ext_irq_pin_a;
  AST_GIM_RSV: assert property (rd && addr == 6'h3B |=> rdata[3:0] == 4'h0)
    else $error("mask low bits not zero");
  AST_NO_GIE: assert property (!global_int_enable |-> !(irq_pin_a || irq_pin_b || irq_pin_change))
    else $error("request without global enable");
  AST_A_MASK: assert property (irq_pin_a |-> g[6])
    else $error("pin a request while masked");
  AST_B_MASK: assert property (irq_pin_b |-> g[7])
    else $error("pin b request while masked");
  AST_PC_MASK: assert property (irq_pin_change |-> g[5] || g[4])
    else $error("pin change request with groups off");
  AST_CTL_OUT: assert property (wr && addr == 6'h35 |=>
    {pullup_disable, sleep_enable, sleep_mode_hi, sleep_mode_lo} == $past(wdata[6:3]))
    else $error("control outputs wrong");
  AST_LEVEL: assert property ((lvl && global_int_enable) [*8] |-> irq_pin_a)
    else $error("level request missing");
  AST_WAKE: assert property (lvl |-> wake_req)
    else $error("level wake missing");
  cover property (irq_pin_b);
  cover property (irq_pin_change);
  cover property (wake_req);
endmodule : eiu_chk

bind eiu_top eiu_chk u_chk (.mclk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .ext_irq_pin_a,
  .global_int_enable, .irq_pin_a, .irq_pin_b, .irq_pin_change, .wake_req, .pullup_disable,
  .sleep_enable, .sleep_mode_hi, .sleep_mode_lo);

// >>> eiu_cpu_mdl.sv
// CPU side model: enters a handler for each raised request
module eiu_cpu_mdl (
  input wire logic  mclk,
  input wire logic  rst_n,
  input wire logic  auto_ack,
  input wire logic  irq_pin_a,
  input wire logic  irq_pin_b,
  input wire logic  irq_pin_change,
  output logic       ack_pin_a,
  output logic       ack_pin_b,
  output logic       ack_pin_change,
  output logic [2:0] served
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      {ack_pin_change, ack_pin_b, ack_pin_a} <= 3'h0;
      served <= 3'h0;
    end else begin
      // One entry pulse per vector, then the request must drop
      ack_pin_a <= auto_ack && irq_pin_a && !ack_pin_a;
      ack_pin_b <= auto_ack && irq_pin_b && !ack_pin_b;
      ack_pin_change <= auto_ack && irq_pin_change && !ack_pin_change;
      served <= served | {ack_pin_change, ack_pin_b, ack_pin_a};
    end
  end
endmodule : eiu_cpu_mdl

// >>> test_external_pin_interrupt_unit.sv
// Self-checking testbench for the external pin interrupt unit
module test_external_pin_interrupt_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 0, rst_n = 0, wr = 0, rd = 0, gie = 0, auto_ack = 0;
  logic [5:0]  addr = 6'h00;
  logic [7:0]  wdata = 8'h00, rdata, m, n;
  logic [1:0]  xp = 2'h3;
  logic [15:0] pci = 16'h0000, msk;
  logic        irq_a, irq_b, irq_pc, wake, ack_a, ack_b, ack_pc;
  logic [3:0]  ctl_o;
  logic [2:0]  srv;
  int          bad_count = 0, num_checks = 0, i, k, c, p;
  always #12.5 mclk = ~mclk;
  eiu_top dut (.mclk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .ext_irq_pin_a(xp[0]),
    .ext_irq_pin_b(xp[1]), .pin_change_inputs(pci), .global_int_enable(gie),
    .ack_pin_a(ack_a), .ack_pin_b(ack_b), .ack_pin_change(ack_pc), .irq_pin_a(irq_a),
    .irq_pin_b(irq_b), .irq_pin_change(irq_pc), .wake_req(wake), .pullup_disable(ctl_o[3]),
    .sleep_enable(ctl_o[2]), .sleep_mode_hi(ctl_o[1]), .sleep_mode_lo(ctl_o[0]));
  eiu_cpu_mdl cpu (.mclk, .rst_n, .auto_ack, .irq_pin_a(irq_a), .irq_pin_b(irq_b),
    .irq_pin_change(irq_pc), .ack_pin_a(ack_a), .ack_pin_b(ack_b), .ack_pin_change(ack_pc),
    .served(srv));
  task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task wreg(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wreg
  task rchk(input string nm, input logic [5:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(nm, rdata, e);
  endtask : rchk
  // Longer than the synchroniser and flag latency
  task settle;
    repeat (8) @(posedge mclk);
    #1;
  endtask : settle
  task final_report;
    $display("Checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  initial begin
    void'($urandom(81815));
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rchk("ctl", 6'h35, 8'h00);
    rchk("gim", 6'h3B, 8'h00);
    rchk("mask_a", 6'h23, 8'hC8);
    rchk("mask_b", 6'h22, 8'hFF);
    rchk("unmapped", 6'h10, 8'h00);
    $display("reset test done");
    for (i = 0; i < 4; i++) begin
      m = $urandom;
      wreg(6'h35, m);
      wreg(6'h3B, m);
      rchk("ctl", 6'h35, m & 8'h7B);
      rchk("gim", 6'h3B, m & 8'hF0);
      chk("ctl_out", {4'h0, ctl_o}, {4'h0, m[6:3]});
    end
    $display("register test done");
    @(posedge mclk) gie <= 1'b1;
    wreg(6'h3B, 8'hC0);
    for (c = 1; c < 4; c++) begin
      for (p = 0; p < 2; p++) begin
        wreg(6'h35, c[7:0]);
        wreg(6'h3A, 8'hE0);
        // First a falling, then a rising edge
        for (k = 0; k < 2; k++) begin
          @(posedge mclk) xp[p] <= k[0];
          settle;
          n = (c == 1 || c == 2 + k) ? 8'h40 << p : 8'h00;
          rchk("edge_flag", 6'h3A, n);
          chk("edge_irq", {6'h0, irq_b, irq_a}, {6'h0, n[7:6]});
          wreg(6'h3A, 8'hE0);
          #1 chk("w1c_irq", {6'h0, irq_b, irq_a}, 8'h00);
        end
      end
    end
    $display("edge test done");
    wreg(6'h35, 8'h00);
    @(posedge mclk) xp[0] <= 1'b0;
    settle;
    chk("lvl_irq", {7'h0, irq_a}, 8'h01);
    chk("lvl_wake", {7'h0, wake}, 8'h01);
    rchk("lvl_flag", 6'h3A, 8'h00);
    @(posedge mclk) gie <= 1'b0;
    #1 chk("gie_off", {7'h0, irq_a}, 8'h00);
    @(posedge mclk) begin
      xp[0] <= 1'b1;
      gie <= 1'b1;
    end
    settle;
    chk("lvl_rel", {7'h0, irq_a}, 8'h00);
    $display("level test done");
    for (i = 0; i < 6; i++) begin
      msk = $urandom;
      k = $urandom_range(15, 0);
      c = i % 3 + 1;
      wreg(6'h23, msk[7:0]);
      wreg(6'h22, msk[15:8]);
      wreg(6'h3B, {2'h0, c[1:0], 4'h0});
      wreg(6'h3A, 8'h20);
      n = (msk[k] && ((k >= 8 && k <= 11) ? c[0] : c[1])) ? 8'h20 : 8'h00;
      @(posedge mclk) pci[k] <= ~pci[k];
      #1 chk("pc_wake", {7'h0, wake}, {7'h0, n[5]});
      settle;
      chk("pc_wake_end", {7'h0, wake}, 8'h00);
      rchk("pc_flag", 6'h3A, n);
      chk("pc_irq", {7'h0, irq_pc}, {7'h0, n[5]});
    end
    $display("pin change test done");
    @(posedge mclk) auto_ack <= 1'b1;
    wreg(6'h3B, 8'hC0);
    wreg(6'h35, 8'h02);
    @(posedge mclk) xp[1] <= 1'b0;
    for (k = 0; k < 20 && srv[1] !== 1'b1; k++) @(posedge mclk);
    if (srv[1] !== 1'b1) begin
      bad_count++;
      final_report;
    end
    settle;
    rchk("ack_flag", 6'h3A, n & 8'h20);
    chk("vector", {5'h0, srv}, 8'h02);
    wreg(6'h23, 8'hFF);
    wreg(6'h3B, 8'h30);
    @(posedge mclk) pci[0] <= ~pci[0];
    settle;
    rchk("pc_ack", 6'h3A, 8'h00);
    chk("pc_vector", {5'h0, srv}, 8'h06);
    $display("handler test done");
    final_report;
  end
endmodule : test_external_pin_interrupt_unit
